// File: hw/okac_osc_key_ctrl.v
// Summary of operation
// - Oscillator control writable only under key A1
// - Nonzero autocal field write starts autocalibration
// - Source bit requests RC; crystal needs running
// - Battery auto-switch forces RC on battery
// - Failure auto-switch forces RC on failure
// - I/O gated off while power switch enabled and second output pin high
// - Enabled failure flags raise interrupt request
// - Extended trim slows crystal 122 ppm/step
// - Output lock blocks setting second output
// - Status shows which source drives clocks
// - Status shows crystal not toggling
// - Failure flag set on POR loss, slow crystal
// - Autocal failure flag set on calibration fault
// - Any non-key register write clears the key
// - Key value 3C keeps key, software reset
// - Key 9D unlocks analog and output registers
// - Charger enabled only by select 1010
// - Diode 10 inserts, 01 bypasses, else off
// - Resistor field selects 3k/6k/11k, 00 off
// - Threshold select; above flag set on rise
// - Fall clears above, sets flag, fall event
// - Rise past threshold gives rise event
// - Vref trim under 9D, low bits ~NV trim
`timescale 1ns/1ps
`include "okac_regs.vh"

module okac_osc_key_ctrl (
	input wire I_MCLK,
	input wire I_RST_B,
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [7:0] O_RDATA,
	input wire I_ON_BATTERY,
	input wire I_XT_RUNNING,
	input wire I_XT_SLOW,
	input wire I_POR_SUPPLY_LOST,
	input wire I_ACAL_FAIL,
	input wire I_POWER_SWITCH_ENABLE,
	input wire I_SECOND_OUTPUT_PIN,
	input wire I_VBAT_ABOVE_RISE,
	input wire I_VBAT_BELOW_FALL,
	input wire I_BAT_FLAG_CLR,
	input wire [4:0] I_NV_TRIM,
	output wire O_SOURCE_RC,
	output wire O_CRYSTAL_IDLE,
	output reg O_AUTOCAL_START,
	output wire [1:0] O_AUTOCAL_MODE,
	output wire O_IRQ,
	output wire O_IO_DISABLE,
	output wire [1:0] O_EXT_XTAL_TRIM,
	output wire [8:0] O_XTAL_SLOW_PPM,
	output wire O_SECOND_OUTPUT_CONTROL_BIT_SET_INHIBIT,
	output reg O_SW_RESET,
	output wire O_CHARGE_EN,
	output wire O_DIODE_INSERT,
	output wire [1:0] O_CHARGE_RES,
	output wire [3:0] O_BAT_THRESH_SEL,
	output wire O_BAT_ABOVE,
	output wire O_BAT_FLAG,
	output reg O_BL_FALL_EVT,
	output reg O_BL_RISE_EVT,
	output wire [7:0] O_VREF_TRIM,
	output wire [7:0] O_OUT_CTRL
);

	reg [7:0] osc_ctrl_r;
	reg [7:0] stat_rw_r;
	reg [7:0] key_r;
	reg [7:0] trickle_r;
	reg [7:0] battery_threshold_select_r;
	reg [7:0] vref_r;
	reg [7:0] out_ctrl_r;
	reg src_rc_r;
	reg src_rc_nxt;
	reg bat_above_r;
	reg bat_flag_r;
	reg nv_load_r;
	reg of_nxt;
	reg acf_nxt;
	reg [7:0] rdata_nxt;
	wire [1:0] trickle_dec;
	wire [7:0] stat_view;
	wire want_rc;
	wire osc_fail;

	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input we;
		begin
			wr_hit = we && (addr == target);
		end
	endfunction

	function flag_next;
		input cur;
		input clr_wr;
		input wbit;
		input set;
		begin
			// Hardware set wins over a software clear in the same cycle
			if (set) begin
				flag_next = 1'b1;
			end else if (clr_wr) begin
				flag_next = wbit;
			end else begin
				flag_next = cur;
			end
		end
	endfunction

	// Returns {charge enable, diode insert}
	function [1:0] trickle_decode;
		input [7:0] cfg;
		reg sel_ok;
		reg diode_ok;
		reg res_ok;
		begin
			sel_ok = (cfg[`OKAC_TC_SEL_HI:`OKAC_TC_SEL_LO] ==
				`OKAC_TC_SEL_ON);
			diode_ok = (cfg[`OKAC_TC_DIODE_HI:`OKAC_TC_DIODE_LO] ==
				`OKAC_TC_DIODE_IN) ||
				(cfg[`OKAC_TC_DIODE_HI:`OKAC_TC_DIODE_LO] ==
				`OKAC_TC_DIODE_BYP);
			res_ok = (cfg[`OKAC_TC_RES_HI:`OKAC_TC_RES_LO] !=
				`OKAC_TC_RES_OFF);
			trickle_decode[1] = sel_ok && diode_ok && res_ok;
			trickle_decode[0] = sel_ok && diode_ok && res_ok &&
				(cfg[`OKAC_TC_DIODE_HI:`OKAC_TC_DIODE_LO] ==
				`OKAC_TC_DIODE_IN);
		end
	endfunction

	wire wr_osc = wr_hit(I_ADDR, `OKAC_OSC_CTRL_ADDR, I_WR) &&
		(key_r == `OKAC_KEY_OSC);
	wire key_analog = (key_r == `OKAC_KEY_ANALOG);
	wire wr_stat = wr_hit(I_ADDR, `OKAC_OSC_STAT_ADDR, I_WR);
	wire wr_key = wr_hit(I_ADDR, `OKAC_KEY_ADDR, I_WR);
	wire wr_trk = wr_hit(I_ADDR, `OKAC_TRICKLE_ADDR, I_WR) && key_analog;
	wire wr_battery_threshold_select = wr_hit(I_ADDR, `OKAC_BATTERY_THRESHOLD_SELECT_ADDR, I_WR) && key_analog;
	wire wr_vref = wr_hit(I_ADDR, `OKAC_VREF_ADDR, I_WR) &&
		key_analog;
	wire wr_outc = wr_hit(I_ADDR, `OKAC_OUT_CTRL_ADDR, I_WR) && key_analog;

	assign osc_fail = I_XT_SLOW;

	assign want_rc = osc_ctrl_r[`OKAC_OC_SRC_BIT] ||
		(osc_ctrl_r[`OKAC_OC_BATSW_BIT] && I_ON_BATTERY) ||
		(osc_ctrl_r[`OKAC_OC_FAILSW_BIT] &&
		stat_rw_r[`OKAC_OS_OF_BIT]);

	always @* begin
		// Fall back to crystal only while it is actually running
		if (want_rc) begin
			src_rc_nxt = 1'b1;
		end else if (I_XT_RUNNING) begin
			src_rc_nxt = 1'b0;
		end else begin
			src_rc_nxt = src_rc_r;
		end
	end

	always @* begin
		of_nxt = flag_next(stat_rw_r[`OKAC_OS_OF_BIT], wr_stat,
			I_WDATA[`OKAC_OS_OF_BIT],
			I_POR_SUPPLY_LOST || osc_fail);
		acf_nxt = flag_next(stat_rw_r[`OKAC_OS_ACF_BIT], wr_stat,
			I_WDATA[`OKAC_OS_ACF_BIT], I_ACAL_FAIL);
	end

	assign stat_view = {stat_rw_r[`OKAC_OS_XTRIM_HI:`OKAC_OS_XTRIM_LO],
		stat_rw_r[`OKAC_OS_LOCK_BIT],
		src_rc_r,
		~I_XT_RUNNING,
		1'b0,
		stat_rw_r[`OKAC_OS_OF_BIT],
		stat_rw_r[`OKAC_OS_ACF_BIT]};

	// Oscillator control, written only under the oscillator key
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			osc_ctrl_r <= `OKAC_OSC_CTRL_RST;
			O_AUTOCAL_START <= 1'b0;
		end else begin
			if (wr_osc) begin
				osc_ctrl_r <= I_WDATA;
			end
			O_AUTOCAL_START <= wr_osc &&
				(I_WDATA[`OKAC_OC_ACAL_HI:`OKAC_OC_ACAL_LO] != 2'h0);
		end
	end

	// Active source follows the request once the crystal allows it
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			src_rc_r <= 1'b0;
		end else begin
			src_rc_r <= src_rc_nxt;
		end
	end

	// Status: trim and lock are plain bits, flags are set by hardware
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			stat_rw_r <= `OKAC_OSC_STAT_RST;
		end else begin
			stat_rw_r[`OKAC_OS_OF_BIT] <= of_nxt;
			stat_rw_r[`OKAC_OS_ACF_BIT] <= acf_nxt;
			if (wr_stat) begin
				stat_rw_r[7:5] <= I_WDATA[7:5];
			end
			stat_rw_r[4:2] <= 3'h0;
		end
	end

	// Key: any other register write wipes it
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			key_r <= `OKAC_KEY_RST;
			O_SW_RESET <= 1'b0;
		end else begin
			if (wr_key && I_WDATA == `OKAC_KEY_SWRST) begin
				key_r <= key_r;
			end else if (wr_key) begin
				key_r <= I_WDATA;
			end else if (I_WR) begin
				key_r <= `OKAC_KEY_CLEARED;
			end
			O_SW_RESET <= wr_key && (I_WDATA == `OKAC_KEY_SWRST);
		end
	end

	// Analog registers, written only under the analog key
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			trickle_r <= `OKAC_TRICKLE_RST;
			battery_threshold_select_r <= `OKAC_BATTERY_THRESHOLD_SELECT_RST;
			out_ctrl_r <= `OKAC_OUT_CTRL_RST;
		end else begin
			if (wr_trk) begin
				trickle_r <= I_WDATA;
			end
			if (wr_battery_threshold_select) begin
				battery_threshold_select_r <= I_WDATA;
			end
			if (wr_outc) begin
				out_ctrl_r <= I_WDATA & `OKAC_OUT_CTRL_MASK;
			end
		end
	end

	// First edge after reset takes the inverted trim; a write then is lost
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			vref_r <= `OKAC_VREF_RST;
			nv_load_r <= 1'b1;
		end else begin
			if (nv_load_r) begin
				vref_r[`OKAC_VR_NV_HI:`OKAC_VR_NV_LO] <= ~I_NV_TRIM;
				nv_load_r <= 1'b0;
			end else if (wr_vref) begin
				vref_r <= I_WDATA;
			end
		end
	end

	// Battery comparator with hysteresis on the selected threshold pair
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			bat_above_r <= 1'b0;
			bat_flag_r <= 1'b0;
			O_BL_FALL_EVT <= 1'b0;
			O_BL_RISE_EVT <= 1'b0;
		end else begin
			O_BL_FALL_EVT <= 1'b0;
			O_BL_RISE_EVT <= 1'b0;
			if (!bat_above_r && I_VBAT_ABOVE_RISE) begin
				bat_above_r <= 1'b1;
				O_BL_RISE_EVT <= 1'b1;
			end else if (bat_above_r && I_VBAT_BELOW_FALL) begin
				bat_above_r <= 1'b0;
				O_BL_FALL_EVT <= 1'b1;
			end
			if (bat_above_r && I_VBAT_BELOW_FALL) begin
				bat_flag_r <= 1'b1;
			end else if (I_BAT_FLAG_CLR) begin
				bat_flag_r <= 1'b0;
			end
		end
	end

	always @* begin
		case (I_ADDR)
		`OKAC_OSC_CTRL_ADDR: rdata_nxt = osc_ctrl_r;
		`OKAC_OSC_STAT_ADDR: rdata_nxt = stat_view;
		`OKAC_KEY_ADDR: rdata_nxt = key_r;
		`OKAC_TRICKLE_ADDR: rdata_nxt = trickle_r;
		`OKAC_BATTERY_THRESHOLD_SELECT_ADDR: rdata_nxt = battery_threshold_select_r;
		`OKAC_VREF_ADDR: rdata_nxt = vref_r;
		`OKAC_ASTAT_ADDR: rdata_nxt = {bat_above_r, 7'h00};
		`OKAC_OUT_CTRL_ADDR: rdata_nxt = out_ctrl_r;
		default: rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RDATA <= 8'h00;
		end else if (I_RD) begin
			O_RDATA <= rdata_nxt;
		end
	end

	assign O_SOURCE_RC = src_rc_r;
	assign O_CRYSTAL_IDLE = ~I_XT_RUNNING;
	assign O_AUTOCAL_MODE = osc_ctrl_r[`OKAC_OC_ACAL_HI:`OKAC_OC_ACAL_LO];
	assign O_IRQ = (osc_ctrl_r[`OKAC_OC_OSC_FAIL_IRQ_ENABLE_BIT] &&
		stat_rw_r[`OKAC_OS_OF_BIT]) ||
		(osc_ctrl_r[`OKAC_OC_AUTOCAL_FAIL_IRQ_ENABLE_BIT] &&
		stat_rw_r[`OKAC_OS_ACF_BIT]);
	assign O_IO_DISABLE = osc_ctrl_r[`OKAC_OC_IOGATE_BIT] &&
		I_POWER_SWITCH_ENABLE && I_SECOND_OUTPUT_PIN;
	assign O_EXT_XTAL_TRIM = stat_rw_r[`OKAC_OS_XTRIM_HI:`OKAC_OS_XTRIM_LO];
	assign O_XTAL_SLOW_PPM = `OKAC_XTRIM_STEP_PPM *
		{7'h00, O_EXT_XTAL_TRIM};
	assign O_SECOND_OUTPUT_CONTROL_BIT_SET_INHIBIT = stat_rw_r[`OKAC_OS_LOCK_BIT];
	assign trickle_dec = trickle_decode(trickle_r);
	assign O_CHARGE_EN = trickle_dec[1];
	assign O_DIODE_INSERT = trickle_dec[0];
	assign O_CHARGE_RES = trickle_r[`OKAC_TC_RES_HI:`OKAC_TC_RES_LO];
	assign O_BAT_THRESH_SEL = battery_threshold_select_r[`OKAC_BR_SEL_HI:`OKAC_BR_SEL_LO];
	assign O_BAT_ABOVE = bat_above_r;
	assign O_BAT_FLAG = bat_flag_r;
	assign O_VREF_TRIM = vref_r;
	assign O_OUT_CTRL = out_ctrl_r;

endmodule

// File: shared/okac_regs.vh
`ifndef OKAC_REGS_VH
`define OKAC_REGS_VH

// Register addresses
`define OKAC_OSC_CTRL_ADDR 8'h1C
`define OKAC_OSC_STAT_ADDR 8'h1D
`define OKAC_KEY_ADDR 8'h1F
`define OKAC_TRICKLE_ADDR 8'h20
`define OKAC_BATTERY_THRESHOLD_SELECT_ADDR 8'h21
`define OKAC_VREF_ADDR 8'h26
`define OKAC_ASTAT_ADDR 8'h2F
`define OKAC_OUT_CTRL_ADDR 8'h30

// Reset values
`define OKAC_OSC_CTRL_RST 8'h00
`define OKAC_OSC_STAT_RST 8'h00
`define OKAC_KEY_RST 8'h00
`define OKAC_TRICKLE_RST 8'h00
`define OKAC_BATTERY_THRESHOLD_SELECT_RST 8'h00
`define OKAC_VREF_RST 8'h00
`define OKAC_OUT_CTRL_RST 8'h00

// Key values
`define OKAC_KEY_OSC 8'hA1
`define OKAC_KEY_SWRST 8'h3C
`define OKAC_KEY_ANALOG 8'h9D
`define OKAC_KEY_CLEARED 8'h00

// Oscillator control fields
`define OKAC_OC_SRC_BIT 7
`define OKAC_OC_ACAL_HI 6
`define OKAC_OC_ACAL_LO 5
`define OKAC_OC_BATSW_BIT 4
`define OKAC_OC_FAILSW_BIT 3
`define OKAC_OC_IOGATE_BIT 2
`define OKAC_OC_OSC_FAIL_IRQ_ENABLE_BIT 1
`define OKAC_OC_AUTOCAL_FAIL_IRQ_ENABLE_BIT 0

// Oscillator status fields
`define OKAC_OS_XTRIM_HI 7
`define OKAC_OS_XTRIM_LO 6
`define OKAC_OS_LOCK_BIT 5
`define OKAC_OS_MODE_BIT 4
`define OKAC_OS_XTIDLE_BIT 3
`define OKAC_OS_OF_BIT 1
`define OKAC_OS_ACF_BIT 0

// Trickle charger fields and codes
`define OKAC_TC_SEL_HI 7
`define OKAC_TC_SEL_LO 4
`define OKAC_TC_DIODE_HI 3
`define OKAC_TC_DIODE_LO 2
`define OKAC_TC_RES_HI 1
`define OKAC_TC_RES_LO 0
`define OKAC_TC_SEL_ON 4'hA
`define OKAC_TC_DIODE_IN 2'h2
`define OKAC_TC_DIODE_BYP 2'h1
`define OKAC_TC_RES_OFF 2'h0

// Battery reference and analog status
`define OKAC_BR_SEL_HI 7
`define OKAC_BR_SEL_LO 4
`define OKAC_AS_ABOVE_BIT 7

// Voltage reference trim: low bits loaded from nonvolatile trim
`define OKAC_VR_NV_HI 4
`define OKAC_VR_NV_LO 0

// Output control writable bits
`define OKAC_OUT_CTRL_MASK 8'hC0

// Extended crystal trim step in ppm
`define OKAC_XTRIM_STEP_PPM 9'd122

`endif

// File: tb/okac_osc_key_ctrl_properties.sv
`timescale 1ns/1ps
module okac_osc_key_ctrl_properties (
	input wire I_MCLK,
	input wire I_RST_B,
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_XT_RUNNING,
	input wire I_VBAT_ABOVE_RISE,
	input wire I_VBAT_BELOW_FALL,
	input wire O_CRYSTAL_IDLE,
	input wire O_AUTOCAL_START,
	input wire [1:0] O_AUTOCAL_MODE,
	input wire [1:0] O_EXT_XTAL_TRIM,
	input wire [8:0] O_XTAL_SLOW_PPM,
	input wire O_SW_RESET,
	input wire O_CHARGE_EN,
	input wire [1:0] O_CHARGE_RES,
	input wire O_BAT_ABOVE,
	input wire O_BAT_FLAG,
	input wire O_BL_FALL_EVT,
	input wire O_BL_RISE_EVT
);
	reg [7:0] key_r;
	wire wk = I_WR && I_ADDR == 8'h1F;
	wire wo = I_WR && I_ADDR == 8'h1C;
	wire wt = I_WR && I_ADDR == 8'h20;
	// Shadow key, so protected writes can be judged from the ports
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B)
			key_r <= 8'h00;
		else if (wk && I_WDATA != 8'h3C)
			key_r <= I_WDATA;
		else if (I_WR && !wk)
			key_r <= 8'h00;
	end
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	osc_lock_a: assert property (wo && key_r != 8'hA1
		|=> $stable(O_AUTOCAL_MODE) && !O_AUTOCAL_START) else $error("osc leak");
	acal_go_a: assert property (wo && key_r == 8'hA1
		&& I_WDATA[6:5] != 2'h0 |=> O_AUTOCAL_START) else $error("no acal");
	sw_reset_a: assert property (wk && I_WDATA == 8'h3C
		|=> O_SW_RESET) else $error("no sw reset");
	xt_idle_a: assert property (O_CRYSTAL_IDLE == !I_XT_RUNNING)
		else $error("idle flag");
	trim_ppm_a: assert property (
		O_XTAL_SLOW_PPM == O_EXT_XTAL_TRIM * 9'd122) else $error("ppm");
	trk_lock_a: assert property (wt && key_r != 8'h9D
		|=> $stable(O_CHARGE_RES) && $stable(O_CHARGE_EN)) else $error("trk");
	bat_rise_a: assert property (!O_BAT_ABOVE && I_VBAT_ABOVE_RISE
		|=> O_BAT_ABOVE && O_BL_RISE_EVT) else $error("rise");
	bat_fall_a: assert property (O_BAT_ABOVE && I_VBAT_BELOW_FALL
		|=> !O_BAT_ABOVE && O_BAT_FLAG && O_BL_FALL_EVT) else $error("fall");
	cover property (O_AUTOCAL_START);
	cover property (O_SW_RESET);
	cover property (O_BL_FALL_EVT);
endmodule
bind okac_osc_key_ctrl okac_osc_key_ctrl_properties u_chk (
	.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_XT_RUNNING(I_XT_RUNNING),
	.I_VBAT_ABOVE_RISE(I_VBAT_ABOVE_RISE),
	.I_VBAT_BELOW_FALL(I_VBAT_BELOW_FALL), .O_CRYSTAL_IDLE(O_CRYSTAL_IDLE),
	.O_AUTOCAL_START(O_AUTOCAL_START), .O_AUTOCAL_MODE(O_AUTOCAL_MODE),
	.O_EXT_XTAL_TRIM(O_EXT_XTAL_TRIM), .O_XTAL_SLOW_PPM(O_XTAL_SLOW_PPM),
	.O_SW_RESET(O_SW_RESET), .O_CHARGE_EN(O_CHARGE_EN),
	.O_CHARGE_RES(O_CHARGE_RES), .O_BAT_ABOVE(O_BAT_ABOVE),
	.O_BAT_FLAG(O_BAT_FLAG), .O_BL_FALL_EVT(O_BL_FALL_EVT),
	.O_BL_RISE_EVT(O_BL_RISE_EVT)
);

// File: tb/okac_osc_key_ctrl_bench.sv
`timescale 1ns/1ps
module okac_osc_key_ctrl_bench;
	localparam [39:0] TV = 40'h55A8ADA9A5;
	localparam [9:0] TE = 10'b0000001110;
	reg clk, rst_b, we, re, onb, xtr, xts, acf, pse, sop, vr, vf, fclr;
	reg [7:0] adr, wd;
	reg [4:0] nv;
	wire [7:0] rdat, vref, outc;
	wire src, idle, acs, irq, iod, inh, swr, chen, dins, above, flag, fev, rev;
	wire [1:0] xtt, cres;
	wire [8:0] ppm;
	wire [3:0] bsel;
	integer n_mismatch, checks, cyc, i;
	okac_osc_key_ctrl DUT (
		.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(adr), .I_WDATA(wd),
		.I_WR(we), .I_RD(re), .O_RDATA(rdat), .I_ON_BATTERY(onb),
		.I_XT_RUNNING(xtr), .I_XT_SLOW(xts), .I_POR_SUPPLY_LOST(1'b0),
		.I_ACAL_FAIL(acf), .I_POWER_SWITCH_ENABLE(pse),
		.I_SECOND_OUTPUT_PIN(sop), .I_VBAT_ABOVE_RISE(vr),
		.I_VBAT_BELOW_FALL(vf), .I_BAT_FLAG_CLR(fclr), .I_NV_TRIM(nv),
		.O_SOURCE_RC(src), .O_CRYSTAL_IDLE(idle), .O_AUTOCAL_START(acs),
		.O_AUTOCAL_MODE(), .O_IRQ(irq), .O_IO_DISABLE(iod),
		.O_EXT_XTAL_TRIM(xtt), .O_XTAL_SLOW_PPM(ppm),
		.O_SECOND_OUTPUT_CONTROL_BIT_SET_INHIBIT(inh), .O_SW_RESET(swr), .O_CHARGE_EN(chen),
		.O_DIODE_INSERT(dins), .O_CHARGE_RES(cres), .O_BAT_THRESH_SEL(bsel),
		.O_BAT_ABOVE(above), .O_BAT_FLAG(flag), .O_BL_FALL_EVT(fev),
		.O_BL_RISE_EVT(rev), .O_VREF_TRIM(vref), .O_OUT_CTRL(outc)
	);
	task chk(input [15:0] g, e, input [63:0] m);
		checks = checks + 1;
		if (g !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %0t %0s", $time, m);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input [7:0] a, d);
		adr = a;
		wd = d;
		we = 1'b1;
		tick(1);
		we = 1'b0;
	endtask
	task kw(input [7:0] k, a, d);
		wr(8'h1F, k);
		wr(a, d);
	endtask
	task rd(input [7:0] a, m, e);
		adr = a;
		re = 1'b1;
		tick(1);
		re = 1'b0;
		chk(rdat & m, e, "read");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task t_reset;
		chk(vref[4:0], {4'h0, ~nv}, "nv trim");
		rd(8'h1C, 8'hFF, 8'h00); // register table
		rd(8'h1D, 8'hFF, 8'h00); // register table
		rd(8'h1F, 8'hFF, 8'h00); // register table
		rd(8'h20, 8'hFF, 8'h00); // register table
		rd(8'h21, 8'hFF, 8'h00); // register table
		rd(8'h3E, 8'hFF, 8'h00); // unmapped
		$display("reset test done");
	endtask
	task t_osc;
		wr(8'h1C, 8'h60);
		rd(8'h1C, 8'hFF, 8'h00);
		kw(8'hA1, 8'h1C, 8'h60);
		chk(acs, 1'b1, "acal");
		rd(8'h1F, 8'hFF, 8'h00);
		wr(8'h1F, 8'hA1);
		wr(8'h1D, 8'h00);
		wr(8'h1C, 8'h80);
		rd(8'h1C, 8'hFF, 8'h60);
		$display("osc test done");
	endtask
	task t_src;
		kw(8'hA1, 8'h1C, 8'h80);
		tick(2);
		chk(src, 1'b1, "rc");
		rd(8'h1D, 8'h10, 8'h10);
		xtr = 1'b0;
		kw(8'hA1, 8'h1C, 8'h00);
		tick(2);
		chk(src, 1'b1, "xt dead");
		rd(8'h1D, 8'h08, 8'h08);
		chk(idle, 1'b1, "idle");
		xtr = 1'b1;
		tick(2);
		chk(src, 1'b0, "xt");
		kw(8'hA1, 8'h1C, 8'h10);
		onb = 1'b1;
		tick(2);
		chk(src, 1'b1, "bat");
		onb = 1'b0;
		tick(2);
		chk(src, 1'b0, "mains");
		$display("source test done");
	endtask
	task t_irq;
		kw(8'hA1, 8'h1C, 8'h0F);
		xts = 1'b1;
		tick(1);
		xts = 1'b0;
		tick(2);
		chk({irq, src, iod}, 3'b110, "ofail");
		rd(8'h1D, 8'h03, 8'h02);
		pse = 1'b1;
		sop = 1'b1;
		wr(8'h1D, 8'h00);
		tick(2);
		chk({irq, src, iod}, 3'b001, "clear");
		acf = 1'b1;
		tick(1);
		acf = 1'b0;
		tick(2);
		chk(irq, 1'b1, "acfail");
		rd(8'h1D, 8'h03, 8'h01);
		wr(8'h1D, 8'hE0);
		chk({xtt, inh, irq}, 4'hE, "stat");
		chk(ppm, 9'd366, "ppm");
		$display("irq test done");
	endtask
	task t_ana;
		wr(8'h20, 8'hA5);
		chk(chen, 1'b0, "no key");
		for (i = 0; i < 5; i = i + 1) begin
			kw(8'h9D, 8'h20, TV[i*8 +: 8]);
			chk({chen, dins}, TE[i*2 +: 2], "trk");
			chk(cres, TV[i*8 +: 2], "res");
		end
		kw(8'h9D, 8'h30, 8'hC0);
		kw(8'h9D, 8'h26, 8'hC3);
		wr(8'h26, 8'h00);
		chk({outc, vref}, 16'hC0C3, "vref");
		kw(8'h9D, 8'h21, 8'h70);
		vr = 1'b1;
		tick(1);
		chk({bsel, above, rev}, 6'h1F, "rise");
		vr = 1'b0;
		vf = 1'b1;
		tick(1);
		chk({above, flag, fev}, 3'b011, "fall");
		vf = 1'b0;
		fclr = 1'b1;
		tick(1);
		fclr = 1'b0;
		chk(flag, 1'b0, "flag clr");
		wr(8'h1F, 8'hA1);
		wr(8'h1F, 8'h3C);
		chk(swr, 1'b1, "swrst");
		rd(8'h1F, 8'hFF, 8'hA1);
		$display("analog test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			test_done;
		end
	end
	initial begin
		{rst_b, we, re, onb, xts, acf, pse, sop, vr, vf, fclr} = 11'h0;
		{adr, wd, nv, xtr, n_mismatch, checks, cyc} = {21'h0016, 1'b1, 96'h0};
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		tick(1);
		t_reset;
		t_osc;
		t_src;
		t_irq;
		t_ana;
		test_done;
	end
endmodule
